// >>> logic/tlpi_pkg.sv
// Constants shared by the two-level interrupt controller files.
// Assumes an 8-bit register port and a 21-bit program counter.
package tlpi_pkg;

  // Register port geometry
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned VEC_W  = 21;

  // Register indices
  localparam logic [ADDR_W-1:0] IDX_RESET_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CTRL   = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CTRL2  = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_FLAG       = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_ENABLE     = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_PRIORITY   = 3'h5;
  localparam logic [ADDR_W-1:0] IDX_STATUS     = 3'h6;

  // Field positions
  localparam int unsigned BIT_PLE     = 7;
  localparam int unsigned BIT_GIE_HI  = 7;
  localparam int unsigned BIT_GIE_LO  = 6;
  localparam int unsigned BIT_ACT_HI  = 0;
  localparam int unsigned BIT_ACT_LO  = 1;

  // Reset values
  localparam logic [DATA_W-1:0] RST_FLAG     = 8'h00;
  localparam logic [DATA_W-1:0] RST_ENABLE   = 8'h00;
  localparam logic [DATA_W-1:0] RST_PRIORITY = 8'hff;
  localparam logic [DATA_W-1:0] RST_EDGE     = 8'hff;

  // Vector addresses
  localparam logic [VEC_W-1:0] HIGH_VECTOR = 21'h000008;
  localparam logic [VEC_W-1:0] LOW_VECTOR  = 21'h000018;

  // Timing: one instruction cycle is four core clocks
  localparam logic [1:0] ICYC_LAST    = 2'h3;
  localparam logic [2:0] LAT_MIN_ICYC = 3'h3;

endpackage

// >>> logic/tlpi_pin_sync.sv
// Pin synchroniser and edge detector for one external event pin.
// Assumes pin_in is asynchronous to mclk; edge select is from mclk logic.
`timescale 1ns/1ps
module tlpi_pin_sync
  import tlpi_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Pin and edge choice
  input  wire logic pin_in,
  input  wire logic rise_sel,
  // Detected edge
  output logic      edge_pulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } tlpi_sync_state_t;

  tlpi_sync_state_t s_q;
  tlpi_sync_state_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.meta  = pin_in;
    s_d.sync  = s_q.meta;
    s_d.prev  = s_q.sync;
    // Edge taken only from the second stage onward
    s_d.pulse = rise_sel ? (s_q.sync & ~s_q.prev)
                         : (~s_q.sync & s_q.prev);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_pulse = s_q.pulse;

endmodule

// >>> logic/tlpi_ctrl.sv
// Two-level priority interrupt controller for an 8-bit core.
// Assumes core-clock peripheral events, asynchronous event pins, and a
// fetch unit that acts on vector_take in the cycle it is high.
//
// Overview of operation
// R1: High requests vector to 000008h, low requests to 000018h.
// R2: Enabled high request preempts a running low-level routine.
// R3: Each source owns a flag, an enable and a priority bit.
// R4: Two-level operation only while priority_levels_enable is set.
// R5: With levels on, control bit 7 gates all high-priority sources.
// R6: With levels on, control bit 6 gates all low-priority sources.
// R7: Flag, enable and level enable all set vectors by priority bit.
// R8: With levels off, the reset default, priority bits are ignored.
// R9: Compatibility mode: bit 6 gates peripherals, bit 7 gates everything.
// R10: Compatibility mode sends every accepted interrupt to 000008h.
// R11: Accepting an interrupt clears the global enable that admitted it.
// R12: No low request is accepted while a high routine runs.
// R13: Vectoring pushes the return address and loads the vector.
// R14: Software clears serviced flags before enabling interrupts again.
// R15: Return-from-interrupt sets the matching global enable again.
// R16: Pin events vector three to four instruction cycles later.
// R17: Flags set on events regardless of any enable.
// R18: Each source can be masked alone by its enable bit.
// R19: Software never uses memory-to-memory move on these registers.
// R20: Active level is tracked so returns restore the right enable.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tlpi_ctrl
  import tlpi_pkg::*;
#(
  parameter int unsigned NSRC = 8,
  parameter int unsigned NPIN = 4,
  parameter logic [NSRC-1:0] PERIPH_MASK = 8'hf0
)(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Event sources
  input  wire logic [NSRC-1:0]   src_event,
  input  wire logic [NPIN-1:0]   ext_pin,
  // Core fetch side
  input  wire logic [VEC_W-1:0]  ret_pc,
  input  wire logic              return_from_interrupt,
  output logic                   vector_take,
  output logic                   vector_high,
  output logic      [VEC_W-1:0]  vector_addr,
  output logic      [VEC_W-1:0]  push_addr,
  output logic                   instr_tick
);

  typedef struct packed {
    logic               priority_levels_enable;
    logic               high_level_global_enable;
    logic               low_level_global_enable;
    logic [NPIN-1:0]    edge_rise;
    logic [NSRC-1:0]    flag;
    logic [NSRC-1:0]    enable;
    logic [NSRC-1:0]    prio;
    logic               act_hi;
    logic               act_lo;
    logic [1:0]         phase;
    logic               armed;
    logic [2:0]         lat_cnt;
    logic               take;
    logic               take_hi;
    logic [VEC_W-1:0]   vec;
    logic [VEC_W-1:0]   push;
    logic [DATA_W-1:0]  rdata;
  } tlpi_ctrl_state_t;

  tlpi_ctrl_state_t s_q;
  tlpi_ctrl_state_t s_d;

  logic [NPIN-1:0] pin_edge;
  logic [NSRC-1:0] event_all;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] compat_ok;
  logic            icyc;
  logic            hi_req;
  logic            lo_req;
  logic            any_req;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] idx);
    reg_hit = (a == idx);
  endfunction

  // External pins: synchronise and pick the active edge
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      tlpi_pin_sync u_sync (
        .mclk       (mclk),
        .rst        (rst),
        .pin_in     (ext_pin[gi]),
        .rise_sel   (s_q.edge_rise[gi]),
        .edge_pulse (pin_edge[gi])
      );
    end
  endgenerate

  assign event_all = src_event | {{(NSRC-NPIN){1'b0}}, pin_edge};
  assign icyc      = (s_q.phase == ICYC_LAST);

  // R3: flag and enable qualify each source
  // R18: each enable masks its own source only
  assign pend = s_q.flag & s_q.enable;

  // R9: peripheral sources also need the peripheral enable
  assign compat_ok = pend & (~PERIPH_MASK | {NSRC{s_q.low_level_global_enable}});

  always_comb begin
    hi_req = 1'b0;
    lo_req = 1'b0;
    if (s_q.priority_levels_enable) begin
      // R4: two-level decode
      // R5: high-level global enable
      hi_req = s_q.high_level_global_enable & |(pend & s_q.prio);
      // R6: low-level global enable
      // R12: low requests held off during a high routine
      lo_req = s_q.low_level_global_enable & ~s_q.act_hi
               & |(pend & ~s_q.prio);
    end else begin
      // R8: priority bits unused
      // R9: single global enable gates everything
      hi_req = s_q.high_level_global_enable & |compat_ok;
    end
  end

  assign any_req = hi_req | lo_req;

  always_comb begin
    s_d       = s_q;
    s_d.take  = 1'b0;
    s_d.rdata = '0;

    // Instruction cycle divider
    s_d.phase = s_q.phase + 2'h1;

    // Register writes
    if (reg_wr) begin
      if (reg_hit(reg_addr, IDX_RESET_CTRL)) begin
        s_d.priority_levels_enable = reg_wdata[BIT_PLE];
      end
      if (reg_hit(reg_addr, IDX_IRQ_CTRL)) begin
        s_d.high_level_global_enable = reg_wdata[BIT_GIE_HI];
        s_d.low_level_global_enable  = reg_wdata[BIT_GIE_LO];
      end
      if (reg_hit(reg_addr, IDX_IRQ_CTRL2)) begin
        s_d.edge_rise = reg_wdata[NPIN-1:0];
      end
      if (reg_hit(reg_addr, IDX_FLAG)) begin
        s_d.flag = reg_wdata[NSRC-1:0];
      end
      if (reg_hit(reg_addr, IDX_ENABLE)) begin
        s_d.enable = reg_wdata[NSRC-1:0];
      end
      if (reg_hit(reg_addr, IDX_PRIORITY)) begin
        s_d.prio = reg_wdata[NSRC-1:0];
      end
    end

    // R17: events set flags, winning over a software clear
    s_d.flag = s_d.flag | event_all;

    // Register reads, data in the following cycle
    if (reg_rd) begin
      if (reg_hit(reg_addr, IDX_RESET_CTRL)) begin
        s_d.rdata[BIT_PLE] = s_q.priority_levels_enable;
      end
      if (reg_hit(reg_addr, IDX_IRQ_CTRL)) begin
        s_d.rdata[BIT_GIE_HI] = s_q.high_level_global_enable;
        s_d.rdata[BIT_GIE_LO] = s_q.low_level_global_enable;
      end
      if (reg_hit(reg_addr, IDX_IRQ_CTRL2)) begin
        s_d.rdata[NPIN-1:0] = s_q.edge_rise;
      end
      if (reg_hit(reg_addr, IDX_FLAG)) begin
        s_d.rdata[NSRC-1:0] = s_q.flag;
      end
      if (reg_hit(reg_addr, IDX_ENABLE)) begin
        s_d.rdata[NSRC-1:0] = s_q.enable;
      end
      if (reg_hit(reg_addr, IDX_PRIORITY)) begin
        s_d.rdata[NSRC-1:0] = s_q.prio;
      end
      if (reg_hit(reg_addr, IDX_STATUS)) begin
        s_d.rdata[BIT_ACT_HI] = s_q.act_hi;
        s_d.rdata[BIT_ACT_LO] = s_q.act_lo;
      end
    end

    // R15: return re-arms the enable of the level that ends
    // R20: high return drops back into a preempted low routine
    if (return_from_interrupt) begin
      if (!s_q.priority_levels_enable || s_q.act_hi || !s_q.act_lo) begin
        s_d.high_level_global_enable = 1'b1;
        s_d.act_hi = 1'b0;
        if (!s_q.priority_levels_enable) begin
          s_d.act_lo = 1'b0;
        end
      end else begin
        s_d.low_level_global_enable = 1'b1;
        s_d.act_lo = 1'b0;
      end
    end

    // R16: counted on instruction boundaries, so instruction length
    // plays no part; a withdrawn request abandons the count
    // Third boundary, first sight included: pin latency stays at
    // three to four instruction cycles despite the synchroniser
    if (!any_req) begin
      s_d.armed   = 1'b0;
      s_d.lat_cnt = '0;
    end else if (!s_q.armed) begin
      s_d.armed   = 1'b1;
      s_d.lat_cnt = icyc ? 3'h1 : 3'h0;
    end else if (icyc) begin
      if (s_q.lat_cnt == LAT_MIN_ICYC - 3'h1) begin
        // R7: vector once all three qualifiers hold
        // R13: push return address, load vector
        s_d.take    = 1'b1;
        s_d.armed   = 1'b0;
        s_d.lat_cnt = '0;
        s_d.push    = ret_pc;
        // R2: high request wins, even inside a low routine
        s_d.take_hi = hi_req;
        // R1: vector by level
        // R10: compatibility mode always takes the high vector
        s_d.vec     = hi_req ? HIGH_VECTOR : LOW_VECTOR;
        // R11: clear the enable that admitted this request
        if (hi_req) begin
          s_d.high_level_global_enable = 1'b0;
          s_d.act_hi = 1'b1;
        end else begin
          s_d.low_level_global_enable = 1'b0;
          s_d.act_lo = 1'b1;
        end
      end else begin
        s_d.lat_cnt = s_q.lat_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.flag   <= RST_FLAG[NSRC-1:0];
      s_q.enable <= RST_ENABLE[NSRC-1:0];
      s_q.prio   <= RST_PRIORITY[NSRC-1:0];
      s_q.edge_rise <= RST_EDGE[NPIN-1:0];
      s_q.vec    <= HIGH_VECTOR;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata   = s_q.rdata;
  assign vector_take = s_q.take;
  assign vector_high = s_q.take_hi;
  assign vector_addr = s_q.vec;
  assign push_addr   = s_q.push;
  assign instr_tick  = icyc;

endmodule

// >>> verif/tlpi_ctrl_checker.sv
// Port-level assertions for the interrupt controller.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module tlpi_ctrl_checker
  import tlpi_pkg::*;
#(
  parameter int unsigned NSRC = 8,
  parameter int unsigned NPIN = 4
)(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Event sources
  input wire logic [NSRC-1:0]   src_event,
  input wire logic [NPIN-1:0]   ext_pin,
  // Core fetch side
  input wire logic [VEC_W-1:0]  ret_pc,
  input wire logic              return_from_interrupt,
  input wire logic              vector_take,
  input wire logic              vector_high,
  input wire logic [VEC_W-1:0]  vector_addr,
  input wire logic [VEC_W-1:0]  push_addr,
  input wire logic              instr_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_vec_hi;
    vector_take && vector_high |-> vector_addr == HIGH_VECTOR;
  endproperty
  a_vec_hi: assert property (p_vec_hi)
    else $error("high take off vector");
  property p_vec_lo;
    vector_take && !vector_high |-> vector_addr == LOW_VECTOR;
  endproperty
  a_vec_lo: assert property (p_vec_lo)
    else $error("low take off vector");
  // Return pc is captured in the cycle before the take shows
  property p_push;
    vector_take |-> push_addr == $past(ret_pc);
  endproperty
  a_push: assert property (p_push)
    else $error("pushed address not the return pc");
  property p_take_pulse;
    vector_take |=> !vector_take;
  endproperty
  a_take_pulse: assert property (p_take_pulse)
    else $error("take longer than one cycle");
  property p_tick;
    instr_tick |=> !instr_tick [*3] ##1 instr_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("instruction tick not one in four");
  property p_take_tick;
    vector_take |-> $past(instr_tick);
  endproperty
  a_take_tick: assert property (p_take_tick)
    else $error("take off an instruction boundary");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without a read");
  property p_status;
    reg_rd && reg_addr == IDX_STATUS |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_status: assert property (p_status)
    else $error("status spare bits set");
  property p_vec_hold;
    !vector_take |-> $stable(vector_addr) && $stable(push_addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector outputs moved without a take");

  c_hi: cover property (vector_take && vector_high);
  c_lo: cover property (vector_take && !vector_high);
  c_ret: cover property (return_from_interrupt);
endmodule

bind tlpi_ctrl tlpi_ctrl_checker #(.NSRC(NSRC), .NPIN(NPIN)) u_chk (
  .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .src_event, .ext_pin, .ret_pc, .return_from_interrupt, .vector_take,
  .vector_high, .vector_addr, .push_addr, .instr_tick);

// >>> verif/tlpi_core_model.sv
// Core fetch model: advancing pc and return-from-interrupt pulses.
// Assumes the bench asks for each return with a one-cycle ret_go.
`timescale 1ns/1ps
module tlpi_core_model
  import tlpi_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Controller side
  input  wire logic             instr_tick,
  output logic      [VEC_W-1:0] ret_pc,
  output logic                  return_from_interrupt,
  // Bench requests
  input  wire logic             ret_go,
  input  wire logic             ret_slow
);
  logic [3:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ret_pc <= 21'h000100;
      cnt_q <= 4'h0;
      return_from_interrupt <= 1'b0;
    end else begin
      // One program word per instruction
      if (instr_tick) begin
        ret_pc <= ret_pc + 21'h000002;
      end
      return_from_interrupt <= (cnt_q == 4'h1);
      if (ret_go) begin
        cnt_q <= ret_slow ? 4'hc : 4'h1;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// >>> verif/test_two_level_priority_interrupt_ctrl.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module test_two_level_priority_interrupt_ctrl;
  import tlpi_pkg::*;
  logic              mclk, rst, reg_wr, reg_rd, rd_d, ret_go, ret_slow;
  logic              return_from_interrupt, vector_take, vector_high;
  logic              instr_tick;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, src_event, e;
  logic [3:0]        ext_pin;
  logic [VEC_W-1:0]  ret_pc, vector_addr, push_addr;
  logic [31:0]       rd_q[$], vec_q[$];
  int                fails, tests_run, seed, n;
  logic [7:0]        rv [8] = '{8'h00, 8'h00, 8'h0f, 8'h00,
                                8'h00, 8'hff, 8'h00, 8'h00};

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  tlpi_ctrl u_tlpi_ctrl (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .src_event, .ext_pin, .ret_pc,
    .return_from_interrupt, .vector_take, .vector_high, .vector_addr,
    .push_addr, .instr_tick);
  tlpi_core_model u_tlpi_core_model (.mclk, .rst, .instr_tick, .ret_pc,
    .return_from_interrupt, .ret_go, .ret_slow);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    if (q.size() == 0) return 'x;
    return q.pop_front();
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    rd_q.push_back(32'(x));
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge mclk);
    src_event <= m;
    @(posedge mclk);
    src_event <= 8'h00;
  endtask
  task automatic wait_hi(input bit tk);
    n = 0;
    while ((tk ? vector_take : return_from_interrupt) !== 1'b1
           && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if ((tk ? vector_take : return_from_interrupt) !== 1'b1) begin
      fails++;
      results();
    end
  endtask
  task automatic take(input logic hi, input logic [VEC_W-1:0] v);
    vec_q.push_back(32'({hi, v}));
    wait_hi(1'b1);
  endtask
  task automatic ret(input logic slow);
    @(posedge mclk);
    ret_go <= 1'b1;
    ret_slow <= slow;
    @(posedge mclk);
    ret_go <= 1'b0;
    wait_hi(1'b0);
  endtask

  // Any take without a note pops an unknown and mismatches
  always @(posedge mclk) begin
    if (rd_d) chk(32'(reg_rdata), pop(rd_q));
    if (vector_take) chk(32'({vector_high, vector_addr}), pop(vec_q));
    rd_d <= reg_rd;
  end

  initial begin
    {rst, reg_wr, reg_rd, ret_go, ret_slow} = 5'h10;
    {reg_addr, reg_wdata, src_event, ext_pin} = '0;
    seed = 43;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wr(IDX_STATUS, 8'hff);
    wr(3'h7, 8'hff);
    foreach (rv[i]) rd(3'(i), rv[i]);
    e = 8'($random(seed));
    pulse(e);
    rd(IDX_FLAG, e);
    wr(IDX_FLAG, 8'h00);
    wr(IDX_PRIORITY, 8'h00);
    wr(IDX_ENABLE, 8'h12);
    wr(IDX_IRQ_CTRL, 8'h80);
    pulse(8'h10);
    repeat (24) @(posedge mclk);
    @(posedge mclk);
    ext_pin <= 4'h2;
    take(1'b1, HIGH_VECTOR);
    chk(32'(n >= 13 && n <= 17), 32'h1);
    rd(IDX_IRQ_CTRL, 8'h00);
    wr(IDX_FLAG, 8'h00);
    ret(1'b0);
    rd(IDX_IRQ_CTRL, 8'h80);
    wr(IDX_IRQ_CTRL, 8'hc0);
    pulse(8'h10);
    take(1'b1, HIGH_VECTOR);
    rd(IDX_IRQ_CTRL, 8'h40);
    wr(IDX_FLAG, 8'h00);
    ret(1'b1);
    wr(IDX_RESET_CTRL, 8'h80);
    wr(IDX_PRIORITY, 8'h02);
    wr(IDX_ENABLE, 8'h10);
    pulse(8'h02);
    repeat (24) @(posedge mclk);
    wr(IDX_FLAG, 8'h00);
    wr(IDX_ENABLE, 8'h12);
    pulse(8'h10);
    take(1'b0, LOW_VECTOR);
    rd(IDX_STATUS, 8'h02);
    rd(IDX_IRQ_CTRL, 8'h80);
    pulse(8'h02);
    take(1'b1, HIGH_VECTOR);
    rd(IDX_STATUS, 8'h03);
    wr(IDX_IRQ_CTRL, 8'h40);
    repeat (24) @(posedge mclk);
    wr(IDX_FLAG, 8'h00);
    ret(1'b0);
    rd(IDX_IRQ_CTRL, 8'hc0);
    rd(IDX_STATUS, 8'h02);
    ret(1'b1);
    rd(IDX_STATUS, 8'h00);
    repeat (3) @(posedge mclk);
    results();
  end
endmodule
